// file: oeft_pkg.sv
package oeft_pkg;

  // ----------------------------------------------------------------
  // Register map (byte address = word index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MANUAL_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_FREQ_SELECT   = 4'h4;
  localparam logic [3:0] ADDR_TRIM          = 4'h8;
  localparam logic [3:0] ADDR_ENABLE_STATUS = 4'hC;

  // ----------------------------------------------------------------
  // Field positions of the manual enable register
  // ----------------------------------------------------------------
  localparam int BIT_EXT       = 7;
  localparam int BIT_FAST      = 6;
  localparam int BIT_SLOW      = 4;
  localparam int BIT_SECONDARY = 3;
  localparam int BIT_CONVERTER = 2;
  localparam logic [7:0] MANUAL_ENABLE_MASK = 8'hDC;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int FREQ_W = 3;
  localparam int TRIM_W = 6;
  localparam logic [7:0] MANUAL_ENABLE_RESET = 8'h00;
  localparam logic [5:0] TRIM_RESET          = 6'h00;

  // Reset oscillator fuse codes
  localparam logic [2:0] FUSE_FAST_1MHZ  = 3'h6;
  localparam logic [2:0] FUSE_FAST_32MHZ = 3'h0;

  // Frequency select codes
  typedef enum logic [2:0] {
    OEFT_F1M   = 3'h0,
    OEFT_F2M   = 3'h1,
    OEFT_RSV2  = 3'h2,
    OEFT_F4M   = 3'h3,
    OEFT_F8M   = 3'h4,
    OEFT_F12M  = 3'h5,
    OEFT_F16M  = 3'h6,
    OEFT_RSV7  = 3'h7
  } oeft_freq_t;

  // Nominal frequency in MHz per code, doubled rate under the PLL
  localparam logic [5:0] MHZ_1  = 6'h01;
  localparam logic [5:0] MHZ_2  = 6'h02;
  localparam logic [5:0] MHZ_4  = 6'h04;
  localparam logic [5:0] MHZ_8  = 6'h08;
  localparam logic [5:0] MHZ_12 = 6'h0C;
  localparam logic [5:0] MHZ_16 = 6'h10;
  localparam logic [5:0] MHZ_24 = 6'h18;
  localparam logic [5:0] MHZ_32 = 6'h20;

endpackage

// file: oeft_osc_ctrl.sv
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - External manual bit keeps external oscillator on, mode from fuse.
// - Fast manual bit keeps fast oscillator on at selected frequency.
// - Slow manual bit keeps the 31 kHz oscillator on.
// - Secondary manual bit keeps it on with bypass and power mode.
// - Converter manual bit keeps the 600 kHz oscillator on.
// - Each enable is its own manual bit OR its own module request.
// - Select codes map to 1..16 MHz, PLL doubles 8..16 MHz codes.
// - Fuse for 1 MHz source loads select code 011 at reset.
// - Fuse for 32 MHz PLL source loads select code 110 at reset.
// - Trim is a signed two's-complement offset.
// - Trim zero is center frequency and the reset default.
// - Unimplemented bits ignore writes and read zero.
module oeft_osc_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Fuses and system configuration
  input  wire logic [2:0]  reset_osc_fuse,
  input  wire logic [2:0]  ext_osc_mode_fuse,
  input  wire logic        pll_source_sel,
  input  wire logic        secondary_bypass,
  input  wire logic        secondary_power_mode,
  // Module requests
  input  wire logic        ext_osc_module_req,
  input  wire logic        fast_osc_module_req,
  input  wire logic        slow_osc_module_req,
  input  wire logic        secondary_osc_module_req,
  input  wire logic        converter_osc_module_req,
  // Oscillator controls
  output logic             ext_osc_enable,
  output logic [2:0]       ext_osc_mode,
  output logic             fast_osc_enable,
  output logic [5:0]       fast_osc_freq_mhz,
  output logic [5:0]       fast_osc_trim_out,
  output logic             slow_osc_enable,
  output logic             secondary_osc_enable,
  output logic             secondary_osc_bypass,
  output logic             secondary_osc_high_power,
  output logic             converter_osc_enable
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]              osc_manual_enable;
  logic [2:0]              fast_freq_select;
  logic [5:0]              fast_freq_trim;
  logic                    strap_pending;
  logic                    ack;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic               sel_en;
  wire logic               sel_frq;
  wire logic               sel_trim;
  wire logic               sel_stat;
  assign sel_en   = avs_address == oeft_pkg::ADDR_MANUAL_ENABLE;
  assign sel_frq  = avs_address == oeft_pkg::ADDR_FREQ_SELECT;
  assign sel_trim = avs_address == oeft_pkg::ADDR_TRIM;
  assign sel_stat = avs_address == oeft_pkg::ADDR_ENABLE_STATUS;
  wire logic               req      = avs_read | avs_write;
  wire logic               wr_lane0 = avs_write & ack & avs_byteenable[0];
  wire logic [2:0]         wr_freq  = avs_writedata[2:0];
  wire logic               freq_rsv = (wr_freq == oeft_pkg::OEFT_RSV2) |
                                      (wr_freq == oeft_pkg::OEFT_RSV7);

  // One wait cycle, then acknowledge
  assign avs_waitrequest = req & ~ack;

  // Acknowledge toggles high for one cycle per request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Manual enable and trim; reset values are constants
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      osc_manual_enable <= oeft_pkg::MANUAL_ENABLE_RESET;
      fast_freq_trim    <= oeft_pkg::TRIM_RESET;
    end else if (wr_lane0 & sel_en) begin
      osc_manual_enable <= avs_writedata[7:0] & oeft_pkg::MANUAL_ENABLE_MASK;
    end else if (wr_lane0 & sel_trim) begin
      fast_freq_trim    <= avs_writedata[5:0];
    end
  end

  // Strap capture of the reset fuse happens on the first edge after release
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_pending    <= 1'b1;
      fast_freq_select <= oeft_pkg::OEFT_F4M;
    end else if (strap_pending) begin
      strap_pending    <= 1'b0;
      if (reset_osc_fuse == oeft_pkg::FUSE_FAST_32MHZ) begin
        fast_freq_select <= oeft_pkg::OEFT_F16M;
      end else begin
        fast_freq_select <= oeft_pkg::OEFT_F4M;
      end
    end else if (wr_lane0 & sel_frq & ~freq_rsv) begin
      fast_freq_select <= wr_freq;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // zero-filled reads
  wire logic [7:0] rd_en   = osc_manual_enable;
  wire logic [7:0] rd_frq  = {5'h00, fast_freq_select};
  wire logic [7:0] rd_trim = {2'h0, fast_freq_trim};
  wire logic [7:0] rd_stat = {ext_osc_enable, fast_osc_enable, 1'b0,
                              slow_osc_enable, secondary_osc_enable,
                              converter_osc_enable, 2'h0};
  wire logic [7:0] rd_mux  = sel_en   ? rd_en   :
                             sel_frq  ? rd_frq  :
                             sel_trim ? rd_trim :
                             sel_stat ? rd_stat : 8'h00;

  // Read data registered; unmapped addresses return zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  // external held on
  assign ext_osc_enable = osc_manual_enable[oeft_pkg::BIT_EXT] |
                          ext_osc_module_req;
  assign ext_osc_mode   = ext_osc_mode_fuse;
  assign fast_osc_enable = osc_manual_enable[oeft_pkg::BIT_FAST] |
                           fast_osc_module_req;
  assign slow_osc_enable = osc_manual_enable[oeft_pkg::BIT_SLOW] |
                           slow_osc_module_req;
  assign secondary_osc_enable = osc_manual_enable[oeft_pkg::BIT_SECONDARY] |
                                secondary_osc_module_req;
  assign secondary_osc_bypass     = secondary_bypass;
  // Power mode is ignored in bypass
  assign secondary_osc_high_power = secondary_power_mode & ~secondary_bypass;
  assign converter_osc_enable = osc_manual_enable[oeft_pkg::BIT_CONVERTER] |
                                converter_osc_module_req;

  // ----------------------------------------------------------------
  // Frequency decode
  // ----------------------------------------------------------------
  // code to MHz
  always_comb begin
    fast_osc_freq_mhz = oeft_pkg::MHZ_4;
    unique case (fast_freq_select)
      oeft_pkg::OEFT_F1M:  fast_osc_freq_mhz = oeft_pkg::MHZ_1;
      oeft_pkg::OEFT_F2M:  fast_osc_freq_mhz = oeft_pkg::MHZ_2;
      oeft_pkg::OEFT_F4M:  fast_osc_freq_mhz = oeft_pkg::MHZ_4;
      oeft_pkg::OEFT_F8M:  fast_osc_freq_mhz = pll_source_sel ?
                             oeft_pkg::MHZ_16 : oeft_pkg::MHZ_8;
      oeft_pkg::OEFT_F12M: fast_osc_freq_mhz = pll_source_sel ?
                             oeft_pkg::MHZ_24 : oeft_pkg::MHZ_12;
      oeft_pkg::OEFT_F16M: fast_osc_freq_mhz = pll_source_sel ?
                             oeft_pkg::MHZ_32 : oeft_pkg::MHZ_16;
      default:             fast_osc_freq_mhz = oeft_pkg::MHZ_4;
    endcase
  end

  assign fast_osc_trim_out = fast_freq_trim;

endmodule

`default_nettype wire

// file: oeft_osc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module oeft_osc_ctrl_properties (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        ext_osc_module_req,
  input wire logic        fast_osc_module_req,
  input wire logic        slow_osc_module_req,
  input wire logic        secondary_osc_module_req,
  input wire logic        converter_osc_module_req,
  input wire logic        ext_osc_enable,
  input wire logic        fast_osc_enable,
  input wire logic        slow_osc_enable,
  input wire logic        secondary_osc_enable,
  input wire logic        converter_osc_enable,
  input wire logic [5:0]  fast_osc_freq_mhz,
  input wire logic [5:0]  fast_osc_trim_out
);
  // ----------------------------
  // Bus and enable checks
  // ----------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Accepted writes to trim and select
  logic acc_w;
  assign acc_w = avs_write && !avs_waitrequest && avs_byteenable[0];
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  a_ext_req_on: assert property (ext_osc_module_req |-> ext_osc_enable)
    else $error("ext enable low");
  a_fast_req_on: assert property (fast_osc_module_req |-> fast_osc_enable)
    else $error("fast enable low");
  a_slow_req_on: assert property (slow_osc_module_req |-> slow_osc_enable)
    else $error("slow enable low");
  a_sec_req_on: assert property (
    secondary_osc_module_req |-> secondary_osc_enable)
    else $error("secondary enable low");
  a_conv_req_on: assert property (
    converter_osc_module_req |-> converter_osc_enable)
    else $error("converter enable low");
  a_trim_write: assert property (
    acc_w && avs_address == oeft_pkg::ADDR_TRIM
    |=> fast_osc_trim_out == $past(avs_writedata[5:0]))
    else $error("trim not loaded");
  a_rsv_hold: assert property (
    acc_w && avs_address == oeft_pkg::ADDR_FREQ_SELECT
    && avs_writedata[2:0] inside {3'h2, 3'h7} |=> $stable(fast_osc_freq_mhz))
    else $error("reserved code changed frequency");
endmodule
bind oeft_osc_ctrl oeft_osc_ctrl_properties u_props (.*);
`default_nettype wire

// file: tb_oscillator_enable_freq_tune.sv
`timescale 1ns/1ps
`default_nettype none
module tb_oscillator_enable_freq_tune;
  logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic pll_source_sel, secondary_bypass, secondary_power_mode;
  logic secondary_osc_bypass, secondary_osc_high_power;
  logic ext_osc_module_req, fast_osc_module_req, slow_osc_module_req;
  logic secondary_osc_module_req, converter_osc_module_req;
  logic ext_osc_enable, fast_osc_enable, slow_osc_enable;
  logic secondary_osc_enable, converter_osc_enable;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0] reset_osc_fuse, ext_osc_mode_fuse, ext_osc_mode;
  logic [5:0] fast_osc_freq_mhz, fast_osc_trim_out;
  logic [4:0] req, en;
  int failures, checks, cyc;
  localparam logic [3:0] AM = oeft_pkg::ADDR_MANUAL_ENABLE;
  localparam logic [3:0] AF = oeft_pkg::ADDR_FREQ_SELECT;
  localparam logic [3:0] AT = oeft_pkg::ADDR_TRIM;
  // Rows: code written, code read back, plain MHz, doubled MHz
  logic [17:0] rows [8] = '{{3'h0, 3'h0, 6'h01, 6'h00},
    {3'h1, 3'h1, 6'h02, 6'h00}, {3'h2, 3'h1, 6'h02, 6'h00},
    {3'h3, 3'h3, 6'h04, 6'h00}, {3'h4, 3'h4, 6'h08, 6'h10},
    {3'h5, 3'h5, 6'h0C, 6'h18}, {3'h6, 3'h6, 6'h10, 6'h20},
    {3'h7, 3'h6, 6'h10, 6'h20}};
  assign {ext_osc_module_req, fast_osc_module_req, slow_osc_module_req,
    secondary_osc_module_req, converter_osc_module_req} = req;
  assign en = {ext_osc_enable, fast_osc_enable, slow_osc_enable,
    secondary_osc_enable, converter_osc_enable};
  oeft_osc_ctrl dut (.*);
  // ----------------------------
  // Clock, timeout and tasks
  // ----------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic do_rst(input logic [2:0] f);
    sys_rst <= 1'b1;
    reset_osc_fuse <= f;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // ----------------------------
  // Main sequence
  // ----------------------------
  initial begin
    {avs_read, avs_write, pll_source_sel, secondary_bypass} <= 4'h0;
    {avs_address, avs_writedata, req, secondary_power_mode} <= '0;
    avs_byteenable <= 4'hF;
    ext_osc_mode_fuse <= 3'h5;
    do_rst(3'h6);
    bus(0, AF, 8'h00);
    chk("reset select", 32'h00000003, q);
    bus(0, AM, 8'h00);
    chk("reset manual", 32'h00000000, q);
    bus(1, AM, 8'hFF);
    bus(0, AM, 8'h00);
    chk("manual", 32'h000000DC, q);
    chk("manual enables", {27'h0, 5'h1F}, {27'h0, en});
    bus(1, AM, 8'h00);
    req <= 5'h1F;
    @(posedge clk_sys);
    chk("module enables", {27'h0, 5'h1F}, {27'h0, en});
    req <= 5'h00;
    @(posedge clk_sys);
    chk("idle enables", 32'h00000000, {27'h0, en});
    chk("ext mode", 32'h00000005, {29'h0, ext_osc_mode});
    secondary_power_mode <= 1'b1;
    @(posedge clk_sys);
    chk("sec power", 32'h00000001, {31'h0, secondary_osc_high_power});
    chk("sec bypass", 32'h00000000, {31'h0, secondary_osc_bypass});
    secondary_bypass <= 1'b1;
    @(posedge clk_sys);
    chk("sec power byp", 32'h00000000, {31'h0, secondary_osc_high_power});
    chk("sec bypass on", 32'h00000001, {31'h0, secondary_osc_bypass});
    secondary_bypass <= 1'b0;
    secondary_power_mode <= 1'b0;
    bus(1, AM, 8'h48);
    bus(0, 4'hC, 8'h00);
    chk("status", 32'h00000048, q);
    bus(1, AM, 8'h00);
    bus(1, AT, 8'hE0);
    bus(0, AT, 8'h00);
    chk("trim", 32'h00000020, q);
    chk("trim out", 32'h00000020, {26'h0, fast_osc_trim_out});
    avs_byteenable <= 4'hE;
    bus(1, AT, 8'h11);
    avs_byteenable <= 4'hF;
    bus(0, AT, 8'h00);
    chk("trim no lane", 32'h00000020, q);
    bus(0, 4'h2, 8'h00);
    chk("unmapped", 32'h00000000, q);
    for (int i = 0; i < 8; i++) begin
      bus(1, AF, {5'h00, rows[i][17:15]});
      bus(0, AF, 8'h00);
      chk("select", {29'h0, rows[i][14:12]}, q);
      chk("mhz", {26'h0, rows[i][11:6]}, {26'h0, fast_osc_freq_mhz});
      if (i >= 4) begin
        pll_source_sel <= 1'b1;
        @(posedge clk_sys);
        chk("pll mhz", {26'h0, rows[i][5:0]}, {26'h0, fast_osc_freq_mhz});
        pll_source_sel <= 1'b0;
      end
    end
    do_rst(3'h0);
    bus(0, AF, 8'h00);
    chk("pll reset select", 32'h00000006, q);
    bus(0, AT, 8'h00);
    chk("reset trim", 32'h00000000, q);
    print_verdict();
  end
endmodule
`default_nettype wire
